/* File: adc_serial_register_port_consts.vh */
`ifndef ADC_SERIAL_REGISTER_PORT_CONSTS_VH
`define ADC_SERIAL_REGISTER_PORT_CONSTS_VH

// ----------------------------------------
// Register select codes
// ----------------------------------------
`define REG_CMD 2'h0
`define REG_SETUP 2'h1
`define REG_TEST 2'h2
`define REG_DATA 2'h3

// ----------------------------------------
// Command register field positions
// ----------------------------------------
`define CMD_DATA_READY_N_BIT 7
`define CMD_ZERO_BIT 6
`define CMD_RS_HI_BIT 5
`define CMD_RS_LO_BIT 4
`define CMD_RW_BIT 3
`define CMD_STANDBY_CTRL_BIT 2
`define CMD_GAIN_HI_BIT 1
`define CMD_GAIN_LO_BIT 0

// ----------------------------------------
// Setup register field positions
// ----------------------------------------
`define SETUP_MD_HI_BIT 7
`define SETUP_MD_LO_BIT 6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CMD_RESET 6'h00
`define SETUP_RESET 8'h28
`define TEST_RESET 8'h00

// ----------------------------------------
// Word lengths and timing counts
// ----------------------------------------
`define LAST_IDX_SHORT 4'h7
`define LAST_IDX_LONG 4'hF
`define DATA_READY_N_HI_MCLK 9'h1F4
`define RESYNC_ONES 6'h20

`endif

/* File: adc_serial_register_port.v */
`timescale 1ns/1ns
`default_nettype none
`include "adc_serial_register_port_consts.vh"

//
// Overview of operation
// - Host serial clock may run or pause freely
// - Drive inverted master clock out on pin
// - Active-low select qualifies transfers; tie low allowed
// - Reset pin returns everything to power-on state
// - Data-ready goes low on new word
// - Data-ready goes high after full word read
// - Unread: high 500 master clocks before update
// - Data-ready low also marks calibration done
// - Output shifter loads from selected register
// - Input shifter writes setup, command or test register
// - Four registers: command, setup, data, test
// - After reset, wait for command write
// - Write: command write then register contents
// - Read: command write then read transfer
// - Command register holds standby and gain
// - Command read returns current data-ready status
// - Setup holds calibration, filter, polarity settings
// - Select code 00 addresses command register
// - Select map 00/01/10/11, then back to command
// - Direction bit 0 writes, 1 reads
// - Leading one holds position until zero arrives
// - Thirty-two high clocks resynchronise interface
module adc_serial_register_port (
   // System clock and reset
   input wire clk,
   input wire rst,
   // Device pins
   input wire sclk,
   input wire cs_n,
   input wire din,
   input wire reset_n,
   input wire mclk_in,
   output reg dout,
   output reg dout_oe,
   output reg data_ready_n,
   output reg mclk_out,
   // Conversion core side
   input wire conv_req,
   input wire [15:0] conv_word,
   input wire cal_done,
   output reg cal_run,
   output reg core_reset,
   output reg standby_ctrl,
   output reg [1:0] gain_sel,
   output reg [7:0] setup_out
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   localparam ST_CMD = 2'h0;
   localparam ST_WR = 2'h1;
   localparam ST_RD = 2'h2;

   reg [4:0] s1_r;
   reg [4:0] s2_r;
   reg [4:0] s3_r;
   reg rst_i_r;
   reg [1:0] state_r;
   reg [3:0] bcnt_r;
   reg [5:0] ones_r;
   reg [15:0] sh_in_r;
   reg [15:0] sh_out_r;
   reg reg_select_hi;
   reg reg_select_lo;
   reg rw_r;
   reg [7:0] test_r;
   reg [15:0] data_r;
   reg upd_busy_r;
   reg [8:0] mcnt_r;

   wire sclk_rise;
   wire sclk_fall;
   wire cs_act;
   wire din_s;
   wire mclk_rise;
   wire [1:0] rs;
   wire [7:0] cmd_nxt;
   wire [15:0] word_nxt;
   wire [1:0] md_nxt;

   // Last bit index of a transfer to the selected register
   function [3:0] last_idx;
      input [1:0] sel;
      begin
         last_idx = (sel == `REG_DATA) ? `LAST_IDX_LONG : `LAST_IDX_SHORT;
      end
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Order: reset_n, mclk_in, din, cs_n, sclk
   always @(posedge clk) begin
      if (rst) begin
         s1_r <= 5'h1B;
         s2_r <= 5'h1B;
         s3_r <= 5'h1B;
      end else begin
         s1_r <= {reset_n, mclk_in, din, cs_n, sclk};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign sclk_rise = s2_r[0] & ~s3_r[0];
   assign sclk_fall = ~s2_r[0] & s3_r[0];
   assign cs_act = ~s2_r[1];
   assign din_s = s2_r[2];
   assign mclk_rise = s2_r[3] & ~s3_r[3];
   assign rs = {reg_select_hi, reg_select_lo};
   assign cmd_nxt = {sh_in_r[6:0], din_s};
   assign word_nxt = {sh_in_r[14:0], din_s};
   assign md_nxt = word_nxt[`SETUP_MD_HI_BIT:`SETUP_MD_LO_BIT];

   // Combined reset: system reset or device reset pin
   always @(posedge clk) begin
      rst_i_r <= rst | ~s2_r[4];
      core_reset <= rst_i_r;
   end

   // ----------------------------------------
   // Serial engine, registers and data-ready
   // ----------------------------------------
   always @(posedge clk) begin
      if (rst_i_r) begin
         state_r <= ST_CMD;
         bcnt_r <= 4'h0;
         ones_r <= 6'h00;
         sh_in_r <= 16'h0000;
         sh_out_r <= 16'h0000;
         {reg_select_hi, reg_select_lo, rw_r, standby_ctrl, gain_sel} <= `CMD_RESET;
         setup_out <= `SETUP_RESET;
         test_r <= `TEST_RESET;
         data_r <= 16'h0000;
         data_ready_n <= 1'b1;
         upd_busy_r <= 1'b0;
         mcnt_r <= 9'h000;
         cal_run <= 1'b0;
         dout <= 1'b0;
         dout_oe <= 1'b0;
         mclk_out <= 1'b1;
      end else begin
         // Inverted master clock and data pin
         mclk_out <= ~s2_r[3];
         dout_oe <= cs_act;
         dout <= sh_out_r[15];
         // Deselect drops a partial word
         if (!cs_act) begin
            bcnt_r <= 4'h0;
         end else if (sclk_rise) begin
            // Count consecutive high input bits
            if (din_s && ones_r != `RESYNC_ONES)
               ones_r <= ones_r + 6'h01;
            else if (!din_s)
               ones_r <= 6'h00;
            if (din_s && ones_r == `RESYNC_ONES - 6'h01) begin
               state_r <= ST_CMD;
               bcnt_r <= 4'h0;
            end else begin
               case (state_r)
                  ST_CMD: begin
                     if (bcnt_r == 4'h0 && din_s) begin
                        bcnt_r <= 4'h0;
                     end else if (bcnt_r == `LAST_IDX_SHORT) begin
                        bcnt_r <= 4'h0;
                        {reg_select_hi, reg_select_lo} <= cmd_nxt[`CMD_RS_HI_BIT:`CMD_RS_LO_BIT];
                        rw_r <= cmd_nxt[`CMD_RW_BIT];
                        standby_ctrl <= cmd_nxt[`CMD_STANDBY_CTRL_BIT];
                        gain_sel <= cmd_nxt[`CMD_GAIN_HI_BIT:`CMD_GAIN_LO_BIT];
                        if (cmd_nxt[`CMD_RW_BIT]) begin
                           state_r <= ST_RD;
                           // Output shifter loaded from selected register
                           case (cmd_nxt[`CMD_RS_HI_BIT:`CMD_RS_LO_BIT])
                              `REG_CMD:
                                 sh_out_r <= {data_ready_n, 1'b0, cmd_nxt[5:0], 8'h00};
                              `REG_SETUP:
                                 sh_out_r <= {setup_out, 8'h00};
                              `REG_TEST:
                                 sh_out_r <= {test_r, 8'h00};
                              default:
                                 sh_out_r <= data_r;
                           endcase
                        end else begin
                           state_r <= ST_WR;
                        end
                     end else begin
                        sh_in_r <= word_nxt;
                        bcnt_r <= bcnt_r + 4'h1;
                     end
                  end
                  ST_WR: begin
                     sh_in_r <= word_nxt;
                     bcnt_r <= bcnt_r + 4'h1;
                     if (bcnt_r == last_idx(rs)) begin
                        bcnt_r <= 4'h0;
                        state_r <= ST_CMD;
                        case (rs)
                           `REG_CMD: begin
                              standby_ctrl <= word_nxt[`CMD_STANDBY_CTRL_BIT];
                              gain_sel <= word_nxt[`CMD_GAIN_HI_BIT:`CMD_GAIN_LO_BIT];
                           end
                           `REG_SETUP: begin
                              setup_out <= word_nxt[7:0];
                              if (md_nxt != 2'h0) begin
                                 cal_run <= 1'b1;
                                 data_ready_n <= 1'b1;
                              end
                           end
                           `REG_TEST:
                              test_r <= word_nxt[7:0];
                           default:
                              test_r <= test_r;
                        endcase
                     end
                  end
                  ST_RD: begin
                     bcnt_r <= bcnt_r + 4'h1;
                     if (bcnt_r == last_idx(rs)) begin
                        bcnt_r <= 4'h0;
                        state_r <= ST_CMD;
                        if (rs == `REG_DATA)
                           data_ready_n <= 1'b1;
                     end
                  end
                  default: begin
                     state_r <= ST_CMD;
                     bcnt_r <= 4'h0;
                  end
               endcase
            end
         end else if (sclk_fall && state_r == ST_RD && bcnt_r != 4'h0) begin
            sh_out_r <= {sh_out_r[14:0], 1'b0};
         end
         // Output update: warn high, then load and go low
         if (conv_req && !upd_busy_r) begin
            upd_busy_r <= 1'b1;
            mcnt_r <= 9'h000;
            data_ready_n <= 1'b1;
         end else if (upd_busy_r && mclk_rise) begin
            mcnt_r <= mcnt_r + 9'h001;
            if (mcnt_r == `DATA_READY_N_HI_MCLK - 9'h001) begin
               upd_busy_r <= 1'b0;
               data_r <= conv_word;
               data_ready_n <= 1'b0;
            end
         end
         // Calibration finished: mode returns to normal
         if (cal_done && cal_run) begin
            cal_run <= 1'b0;
            setup_out[`SETUP_MD_HI_BIT:`SETUP_MD_LO_BIT] <= 2'h0;
            data_r <= conv_word;
            data_ready_n <= 1'b0;
         end
      end
   end

endmodule // adc_serial_register_port

`default_nettype wire

/* File: adc_port_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module adc_port_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pins
   input wire logic cs_n,
   input wire logic reset_n,
   input wire logic mclk_in,
   input wire logic dout_oe,
   input wire logic data_ready_n,
   input wire logic mclk_out,
   // Core side
   input wire logic conv_req,
   input wire logic cal_done,
   input wire logic cal_run,
   input wire logic core_reset,
   input wire logic standby_ctrl,
   input wire logic [1:0] gain_sel,
   input wire logic [7:0] setup_out
);
   logic mclk_r;
   logic [9:0] hi_cnt_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Master clock edges since an update began
   always @(posedge clk) begin
      mclk_r <= mclk_in;
      if (rst || !data_ready_n || conv_req)
         hi_cnt_r <= 10'h000;
      else if (mclk_in && !mclk_r && hi_cnt_r != 10'h3FF)
         hi_cnt_r <= hi_cnt_r + 10'h001;
   end
   property p_mclk; disable iff (rst || core_reset) $rose(mclk_in) |-> ##[1:5] $fell(mclk_out); endproperty
   property p_upd_hi; conv_req |=> data_ready_n; endproperty
   property p_upd_len; $fell(data_ready_n) |-> $past(cal_run) || hi_cnt_r >= 10'h1F3; endproperty
   property p_cal_end; cal_done && cal_run |=> !cal_run && !data_ready_n && setup_out[7:6] == 2'h0; endproperty
   property p_cal_go; $rose(cal_run) |-> ##[0:1] data_ready_n; endproperty
   property p_oe_off; cs_n [*4] |-> !dout_oe; endproperty
   property p_oe_on; disable iff (rst || core_reset) !cs_n [*4] |-> dout_oe; endproperty
   property p_rst_val; core_reset [*2] |-> data_ready_n && mclk_out && !dout_oe && !cal_run && !standby_ctrl
      && gain_sel == 2'h0 && setup_out == 8'h28; endproperty
   property p_rst_pin; !reset_n [*5] |-> core_reset; endproperty
   property p_idle; disable iff (rst || core_reset) cs_n [*4] |=> $stable(standby_ctrl) && $stable(gain_sel); endproperty
   a_mclk: assert property (p_mclk) else $error("mclk_out not inverted");
   a_upd_hi: assert property (p_upd_hi) else $error("ready not high on update");
   a_upd_len: assert property (p_upd_len) else $error("ready high too short");
   a_cal_end: assert property (p_cal_end) else $error("calibration end wrong");
   a_cal_go: assert property (p_cal_go) else $error("ready low in calibration");
   a_oe_off: assert property (p_oe_off) else $error("dout driven unselected");
   a_oe_on: assert property (p_oe_on) else $error("dout not driven");
   a_rst_val: assert property (p_rst_val) else $error("reset values wrong");
   a_rst_pin: assert property (p_rst_pin) else $error("reset pin ignored");
   a_idle: assert property (p_idle) else $error("control changed unselected");
   c_cal: cover property (cal_done && cal_run);
   c_upd: cover property ($fell(data_ready_n) && !cal_run);
   c_sel: cover property (!cs_n && dout_oe);
endmodule // adc_port_chk
bind adc_serial_register_port adc_port_chk u_chk (.clk, .rst, .cs_n, .reset_n, .mclk_in, .dout_oe, .data_ready_n,
   .mclk_out, .conv_req, .cal_done, .cal_run, .core_reset, .standby_ctrl, .gain_sel, .setup_out);
`default_nettype wire

/* File: host_port_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_port_model (
   // Clock
   input wire logic clk,
   // Serial pins
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout
);
   // Idle: clock parked high, unselected
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din = 1'b1;
   end
   // One framed word, 8 or 16 bits, 64 ns clock
   task automatic xfer(input logic [15:0] w, input logic wide, output logic [15:0] r);
      int n;
      n = wide ? 16 : 8;
      r = 16'h0000;
      @(posedge clk) cs_n <= 1'b0;
      repeat (16) @(posedge clk);
      for (int i = n - 1; i >= 0; i--) begin
         sclk <= 1'b0;
         din <= w[i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (2) @(posedge clk);
         r = {r[14:0], dout};
         repeat (2) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      din <= ~w[0];
      repeat (8) @(posedge clk);
   endtask
endmodule // host_port_model
`default_nettype wire

/* File: tb_adc_serial_register_port.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
   $display("ERROR %s exp %0h got %0h", n, e, a); end end
module tb_adc_serial_register_port;
   logic clk, rst, reset_n, mclk_in, conv_req, cal_done, sclk, cs_n, din;
   logic [2:0] mdiv = 3'h0;
   logic [15:0] conv_word, rd;
   wire dout, dout_oe, data_ready_n, mclk_out, cal_run, core_reset, standby_ctrl;
   wire [1:0] gain_sel;
   wire [7:0] setup_out;
   int miscompares = 0;
   int num_checks = 0;
   host_port_model u_host (.clk, .sclk, .cs_n, .din, .dout);
   adc_serial_register_port u_dut (.clk, .rst, .sclk, .cs_n, .din, .reset_n, .mclk_in, .dout, .dout_oe,
      .data_ready_n, .mclk_out, .conv_req, .conv_word, .cal_done, .cal_run, .core_reset, .standby_ctrl,
      .gain_sel, .setup_out);
   // Clock and master clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      mdiv <= mdiv + 3'h1;
      mclk_in <= mdiv[2];
   end
   task results;
      if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Standby and gain via command writes; test register never touched
   task t_cmd;
      u_host.xfer(16'h0006, 1'b0, rd);
      @(negedge clk);
      `CHK("standby_ctrl", 1'b1, standby_ctrl)
      `CHK("gain", 2'h2, gain_sel)
      u_host.xfer(16'h0005, 1'b0, rd);
      u_host.xfer(16'h0008, 1'b0, rd);
      u_host.xfer(16'h0000, 1'b0, rd);
      `CHK("cmd rd", 8'h88, rd[7:0])
   endtask
   // Setup write, data write dropped, read back
   task t_setup;
      u_host.xfer(16'h0010, 1'b0, rd);
      u_host.xfer(16'h001A, 1'b0, rd);
      @(negedge clk);
      `CHK("setup", 8'h1A, setup_out)
      u_host.xfer(16'h0030, 1'b0, rd);
      u_host.xfer(16'h1234, 1'b1, rd);
      u_host.xfer(16'h0018, 1'b0, rd);
      u_host.xfer(16'h0000, 1'b0, rd);
      `CHK("setup rd", 8'h1A, rd[7:0])
   endtask
   // Reset pin
   task t_reset;
      u_host.xfer(16'h0004, 1'b0, rd);
      reset_n <= 1'b0;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      `CHK("standby_ctrl", 1'b0, standby_ctrl)
      `CHK("setup", 8'h28, setup_out)
      repeat (8) @(posedge clk);
   endtask
   // Conversion update, then data read
   task t_update;
      conv_word <= 16'hA5C3;
      conv_req <= 1'b1;
      @(posedge clk) conv_req <= 1'b0;
      @(negedge clk);
      `CHK("rdy hi", 1'b1, data_ready_n)
      for (int i = 0; i < 6000 && data_ready_n !== 1'b0; i++) @(posedge clk);
      `CHK("rdy lo", 1'b0, data_ready_n)
      u_host.xfer(16'h0008, 1'b0, rd);
      u_host.xfer(16'h0000, 1'b0, rd);
      `CHK("cmd rd", 8'h08, rd[7:0])
      u_host.xfer(16'hFF38, 1'b1, rd);
      u_host.xfer(16'h0000, 1'b1, rd);
      `CHK("data", 16'hA5C3, rd)
      `CHK("rdy", 1'b1, data_ready_n)
   endtask
   // Self-calibration
   task t_cal;
      u_host.xfer(16'h0010, 1'b0, rd);
      u_host.xfer(16'h0068, 1'b0, rd);
      @(negedge clk);
      `CHK("cal", 1'b1, cal_run)
      conv_word <= 16'h3C5A;
      cal_done <= 1'b1;
      @(posedge clk) cal_done <= 1'b0;
      repeat (2) @(negedge clk);
      `CHK("rdy", 1'b0, data_ready_n)
      `CHK("setup", 8'h28, setup_out)
      u_host.xfer(16'h0038, 1'b0, rd);
      u_host.xfer(16'h0000, 1'b1, rd);
      `CHK("cal data", 16'h3C5A, rd)
   endtask
   // Main sequence
   initial begin
      rst = 1'b1;
      reset_n = 1'b1;
      conv_req = 1'b0;
      cal_done = 1'b0;
      conv_word = 16'h0000;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      t_cmd;
      t_setup;
      t_reset;
      t_update;
      t_cal;
      results;
   end
   // Watchdog
   initial begin
      repeat (30000) @(posedge clk);
      miscompares++;
      results;
   end
endmodule // tb_adc_serial_register_port
`default_nettype wire
